// File: verilog/tmc_pkg.sv
// Constants shared by the timer module common core.
// Assumes an 8-bit register port and a 4-bit register address.
package tmc_pkg;

  // Register offsets
  localparam logic [3:0] TMC_OFS_CTRL0 = 4'h0;
  localparam logic [3:0] TMC_OFS_CTRL1 = 4'h1;
  localparam logic [3:0] TMC_OFS_CNT_LO = 4'h2;
  localparam logic [3:0] TMC_OFS_CNT_HI = 4'h3;
  localparam logic [3:0] TMC_OFS_CMPA_LO = 4'h4;
  localparam logic [3:0] TMC_OFS_CMPA_HI = 4'h5;
  localparam logic [3:0] TMC_OFS_CMPB_LO = 4'h6;
  localparam logic [3:0] TMC_OFS_CMPB_HI = 4'h7;
  localparam logic [3:0] TMC_OFS_CMPP_LO = 4'h8;
  localparam logic [3:0] TMC_OFS_CMPP_HI = 4'h9;
  localparam logic [3:0] TMC_OFS_INT_STATUS = 4'ha;
  localparam logic [3:0] TMC_OFS_INT_MASK = 4'hb;
  localparam logic [3:0] TMC_OFS_PIN_FUNC = 4'hc;
  localparam logic [3:0] TMC_OFS_PORT_DATA = 4'hd;

  // Control 0 fields
  localparam int TMC_CTRL0_RUN_BIT = 3;
  localparam int TMC_CTRL0_SEL_LSB = 4;
  localparam int TMC_CTRL0_EDGE_BIT = 0;
  // Control 1 fields
  localparam int TMC_CTRL1_MODE_LSB = 6;
  localparam int TMC_CTRL1_ACT_LSB = 4;
  localparam int TMC_CTRL1_CCLR_BIT = 3;
  // Status / mask bit positions
  localparam int TMC_INT_P_BIT = 0;
  localparam int TMC_INT_A_BIT = 1;
  localparam int TMC_INT_B_BIT = 2;
  // Pin function and port data bit positions
  localparam int TMC_PIN0_BIT = 0;
  localparam int TMC_PIN1_BIT = 1;

  // Reset values
  localparam logic [7:0] TMC_RST_CTRL0 = 8'h00;
  localparam logic [7:0] TMC_RST_CTRL1 = 8'h00;
  localparam logic [7:0] TMC_RST_PIN_FUNC = 8'h01;
  localparam logic [7:0] TMC_RST_PORT_DATA = 8'h00;
  localparam logic [7:0] TMC_RST_INT = 8'h00;

  // Clock select codes
  localparam logic [2:0] TMC_CK_SYS_DIV4 = 3'h0;
  localparam logic [2:0] TMC_CK_SYS = 3'h1;
  localparam logic [2:0] TMC_CK_HIGH_DIV16 = 3'h2;
  localparam logic [2:0] TMC_CK_HIGH_DIV64 = 3'h3;
  localparam logic [2:0] TMC_CK_LOW = 3'h4;
  localparam logic [2:0] TMC_CK_NONE = 3'h5;
  localparam logic [2:0] TMC_CK_EXT_A = 3'h6;
  localparam logic [2:0] TMC_CK_EXT_B = 3'h7;

  // Prescaler terminal counts
  localparam logic [5:0] TMC_DIV4_MASK = 6'h03;
  localparam logic [5:0] TMC_DIV16_MASK = 6'h0f;
  localparam logic [5:0] TMC_DIV64_MASK = 6'h3f;

  // Variants
  localparam int TMC_VAR_COMPACT = 0;
  localparam int TMC_VAR_STANDARD = 1;
  localparam int TMC_VAR_ENHANCED = 2;

  typedef enum logic [1:0] {
    TMC_MODE_COMPARE,
    TMC_MODE_TIMER,
    TMC_MODE_PWM,
    TMC_MODE_SINGLE
  } tmc_mode_t;

  typedef enum logic [1:0] {
    TMC_ACT_NONE,
    TMC_ACT_LOW,
    TMC_ACT_HIGH,
    TMC_ACT_TOGGLE
  } tmc_act_t;

endpackage

// File: verilog/tmc_core.sv
// Timer module common core: clock select, counter, comparators A/B/P,
// compare interrupts, output pin control with inversion.
// Assumes a same-clock register master; pins are asynchronous.
`timescale 1ns/1ps

module tmc_core
  import tmc_pkg::*;
#(
  parameter int P_VARIANT = TMC_VAR_ENHANCED,
  parameter int P_CNT_W = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_low_clk,
  input wire logic i_ext_count_in,
  output logic [1:0] o_timer_out_pin,
  output logic [1:0] o_timer_out_pin_oe,
  output logic o_irq
);

  ////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  if (P_VARIANT < TMC_VAR_COMPACT || P_VARIANT > TMC_VAR_ENHANCED) begin : g_bad_variant
    $error("tmc_core: unknown variant");
  end
  if (P_CNT_W < 9 || P_CNT_W > 16) begin : g_bad_width
    $error("tmc_core: counter width must be 9 to 16");
  end

  localparam logic HAS_B = (P_VARIANT == TMC_VAR_ENHANCED);
  localparam logic HAS_SINGLE = (P_VARIANT != TMC_VAR_COMPACT);

  function automatic logic [P_CNT_W-1:0] put_byte(input logic [P_CNT_W-1:0] word, input logic hi,
                                                  input logic [7:0] data);
    logic [15:0] w;
    w = 16'(word);
    if (hi) begin
      w[15:8] = data;
    end else begin
      w[7:0] = data;
    end
    put_byte = w[P_CNT_W-1:0];
  endfunction

  function automatic logic [7:0] get_byte(input logic [P_CNT_W-1:0] word, input logic hi);
    logic [15:0] w;
    w = 16'(word);
    get_byte = hi ? w[15:8] : w[7:0];
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Registers

  logic [7:0] ctrl0;
  logic [7:0] ctrl1;
  logic [P_CNT_W-1:0] cnt;
  logic [P_CNT_W-1:0] cmp_a;
  logic [P_CNT_W-1:0] cmp_b;
  logic [P_CNT_W-1:0] cmp_p;
  logic [2:0] int_status;
  logic [2:0] int_mask;
  logic [1:0] pin_func;
  logic [1:0] port_data;
  logic out_state;
  logic [5:0] prescale;
  logic low_s1, low_s2, low_s3;
  logic ext_s1, ext_s2, ext_s3;

  wire logic wr_ctrl0 = i_wr && (i_addr == TMC_OFS_CTRL0);
  wire logic wr_ctrl1 = i_wr && (i_addr == TMC_OFS_CTRL1);
  wire logic wr_cmpa = i_wr && (i_addr == TMC_OFS_CMPA_LO || i_addr == TMC_OFS_CMPA_HI);
  wire logic wr_cmpb = i_wr && HAS_B && (i_addr == TMC_OFS_CMPB_LO || i_addr == TMC_OFS_CMPB_HI);
  wire logic wr_cmpp = i_wr && (i_addr == TMC_OFS_CMPP_LO || i_addr == TMC_OFS_CMPP_HI);
  wire logic wr_status = i_wr && (i_addr == TMC_OFS_INT_STATUS);
  wire logic wr_mask = i_wr && (i_addr == TMC_OFS_INT_MASK);
  wire logic wr_pin = i_wr && (i_addr == TMC_OFS_PIN_FUNC);
  wire logic wr_port = i_wr && (i_addr == TMC_OFS_PORT_DATA);
  wire logic wr_hi = i_addr[0];

  wire logic run = ctrl0[TMC_CTRL0_RUN_BIT];
  wire logic [2:0] clk_src_sel = ctrl0[TMC_CTRL0_SEL_LSB +: 3];
  wire logic edge_fall = ctrl0[TMC_CTRL0_EDGE_BIT];
  wire logic [1:0] mode_raw = ctrl1[TMC_CTRL1_MODE_LSB +: 2];
  wire logic [1:0] act_raw = ctrl1[TMC_CTRL1_ACT_LSB +: 2];
  wire logic clr_on_a = ctrl1[TMC_CTRL1_CCLR_BIT];

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection

  // Third stage only feeds the edge detectors
  always_ff @(posedge i_clk) begin
    low_s1 <= i_low_clk;
    low_s2 <= low_s1;
    low_s3 <= low_s2;
    ext_s1 <= i_ext_count_in;
    ext_s2 <= ext_s1;
    ext_s3 <= ext_s2;
  end

  wire logic low_edge = low_s2 && !low_s3;
  wire logic ext_edge = edge_fall ? (!ext_s2 && ext_s3) : (ext_s2 && !ext_s3);

  ////////////////////////////////////////////////////////////////////////
  // Clock source selection

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      prescale <= 6'h00;
    end else begin
      prescale <= prescale + 6'h01;
    end
  end

  logic tick_src;
  always_comb begin
    case (clk_src_sel)
      TMC_CK_SYS_DIV4: tick_src = (prescale & TMC_DIV4_MASK) == TMC_DIV4_MASK;
      TMC_CK_SYS: tick_src = 1'b1;
      TMC_CK_HIGH_DIV16: tick_src = (prescale & TMC_DIV16_MASK) == TMC_DIV16_MASK;
      TMC_CK_HIGH_DIV64: tick_src = prescale == TMC_DIV64_MASK;
      TMC_CK_LOW: tick_src = low_edge;
      TMC_CK_NONE: tick_src = 1'b0;
      TMC_CK_EXT_A, TMC_CK_EXT_B: tick_src = ext_edge;
      default: tick_src = 1'b0;
    endcase
  end

  // Stopped or disconnected source gives no tick
  wire logic tick = run && tick_src;

  ////////////////////////////////////////////////////////////////////////
  // Counter and compare

  tmc_mode_t mode;
  always_comb begin
    case (mode_raw)
      2'h0: mode = TMC_MODE_COMPARE;
      2'h1: mode = TMC_MODE_TIMER;
      2'h2: mode = TMC_MODE_PWM;
      2'h3: mode = HAS_SINGLE ? TMC_MODE_SINGLE : TMC_MODE_COMPARE;
      default: mode = TMC_MODE_COMPARE;
    endcase
  end

  // Match is seen on the tick that leaves the value
  wire logic match_a = tick && (cnt == cmp_a);
  wire logic match_b = tick && HAS_B && (cnt == cmp_b);
  wire logic match_p = tick && (cnt == cmp_p);
  wire logic clr_cnt = (mode == TMC_MODE_PWM) ? match_p : (clr_on_a ? match_a : match_p);
  wire logic single_end = (mode == TMC_MODE_SINGLE) && match_a;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      cnt <= '0;
    end else if (tick) begin
      cnt <= clr_cnt ? '0 : cnt + P_CNT_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Interrupt status, set wins over clear

  wire logic [2:0] int_set = {match_b, match_a, match_p};
  wire logic [2:0] int_clr = wr_status ? i_wdata[2:0] : 3'h0;
  wire logic [2:0] next_int_status = ((int_status & ~int_clr) | int_set) & {HAS_B, 2'h3};

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      int_status <= TMC_RST_INT[2:0];
      o_irq <= 1'b0;
    end else begin
      int_status <= next_int_status;
      o_irq <= |(next_int_status & int_mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Output waveform

  tmc_act_t act;
  assign act = tmc_act_t'(act_raw);

  logic next_out;
  always_comb begin
    next_out = out_state;
    case (mode)
      TMC_MODE_COMPARE: begin
        if (match_a) begin
          case (act)
            TMC_ACT_LOW: next_out = 1'b0;
            TMC_ACT_HIGH: next_out = 1'b1;
            TMC_ACT_TOGGLE: next_out = !out_state;
            default: next_out = out_state;
          endcase
        end
      end
      TMC_MODE_PWM: next_out = run && (cnt < cmp_a);
      TMC_MODE_SINGLE: next_out = run && !single_end;
      default: next_out = 1'b0;
    endcase
  end

  wire logic [1:0] pin_level = {2{out_state}} ^ port_data;

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      out_state <= 1'b0;
      o_timer_out_pin <= 2'h0;
      o_timer_out_pin_oe <= 2'h0;
    end else begin
      out_state <= next_out;
      o_timer_out_pin <= pin_level & pin_func;
      o_timer_out_pin_oe <= pin_func;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register writes

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl0 <= TMC_RST_CTRL0;
    end else if (wr_ctrl0) begin
      ctrl0 <= i_wdata;
    end else if (single_end) begin
      ctrl0[TMC_CTRL0_RUN_BIT] <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      ctrl1 <= TMC_RST_CTRL1;
      cmp_a <= '0;
      cmp_b <= '0;
      cmp_p <= '0;
      int_mask <= TMC_RST_INT[2:0];
      pin_func <= TMC_RST_PIN_FUNC[1:0];
      port_data <= TMC_RST_PORT_DATA[1:0];
    end else begin
      if (wr_ctrl1) ctrl1 <= i_wdata;
      if (wr_cmpa) cmp_a <= put_byte(cmp_a, wr_hi, i_wdata);
      if (wr_cmpb) cmp_b <= put_byte(cmp_b, wr_hi, i_wdata);
      if (wr_cmpp) cmp_p <= put_byte(cmp_p, wr_hi, i_wdata);
      if (wr_mask) int_mask <= i_wdata[2:0] & {HAS_B, 2'h3};
      if (wr_pin) pin_func <= i_wdata[TMC_PIN1_BIT:TMC_PIN0_BIT];
      if (wr_port) port_data <= i_wdata[TMC_PIN1_BIT:TMC_PIN0_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register reads

  logic [7:0] rd_mux;
  always_comb begin
    case (i_addr)
      TMC_OFS_CTRL0: rd_mux = ctrl0;
      TMC_OFS_CTRL1: rd_mux = ctrl1;
      TMC_OFS_CNT_LO, TMC_OFS_CNT_HI: rd_mux = get_byte(cnt, wr_hi);
      TMC_OFS_CMPA_LO, TMC_OFS_CMPA_HI: rd_mux = get_byte(cmp_a, wr_hi);
      TMC_OFS_CMPB_LO, TMC_OFS_CMPB_HI: rd_mux = get_byte(cmp_b, wr_hi);
      TMC_OFS_CMPP_LO, TMC_OFS_CMPP_HI: rd_mux = get_byte(cmp_p, wr_hi);
      TMC_OFS_INT_STATUS: rd_mux = {5'h00, int_status};
      TMC_OFS_INT_MASK: rd_mux = {5'h00, int_mask};
      TMC_OFS_PIN_FUNC: rd_mux = {6'h00, pin_func};
      TMC_OFS_PORT_DATA: rd_mux = {6'h00, port_data};
      default: rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      o_rdata <= 8'h00;
    end else begin
      // Read data stands one cycle, zero otherwise
      o_rdata <= i_rd ? rd_mux : 8'h00;
    end
  end

endmodule

// File: tb/tmc_core_checker.sv
// Port-level assertions for the timer core.
// Assumes the tmc_pkg register map and one clock domain.
`timescale 1ns/1ps
module tmc_core_checker
  import tmc_pkg::*;
#(
  parameter int P_VARIANT = TMC_VAR_ENHANCED,
  parameter int P_CNT_W = 10
) (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic i_low_clk,
  input wire logic i_ext_count_in,
  input wire logic [1:0] o_timer_out_pin,
  input wire logic [1:0] o_timer_out_pin_oe,
  input wire logic o_irq
);
  ////////////////////////////////////////
  logic [2:0] mask_sh;
  logic [1:0] pd_sh;
  wire logic wr_pf = i_wr && i_addr == TMC_OFS_PIN_FUNC;
  wire logic wr_mask = i_wr && i_addr == TMC_OFS_INT_MASK;
  wire logic wr_pd = i_wr && i_addr == TMC_OFS_PORT_DATA;
  always_ff @(posedge i_clk) begin
    if (!i_rst_b) begin
      mask_sh <= 3'h0;
      pd_sh <= 2'h0;
    end else begin
      if (wr_mask) mask_sh <= i_wdata[2:0];
      if (wr_pd) pd_sh <= i_wdata[1:0];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_pf_wr;
    wr_pf;
  endsequence
  sequence s_mask_off;
    wr_mask && i_wdata[2:0] == 3'h0;
  endsequence
  AST_PF_WR: assert property (s_pf_wr |-> ##2 o_timer_out_pin_oe == $past(i_wdata[1:0], 2))
    else $error("pin enable not taken from write");
  AST_PF_RD: assert property (i_rd && i_addr == TMC_OFS_PIN_FUNC |=> o_rdata == {6'h00, o_timer_out_pin_oe})
    else $error("pin function readback wrong");
  AST_PIN_OFF: assert property ((o_timer_out_pin & ~o_timer_out_pin_oe) == 2'h0)
    else $error("disabled pin driven high");
  AST_OE_CHG: assert property (!$stable(o_timer_out_pin_oe) |-> $past(wr_pf, 2) || !$past(i_rst_b, 2))
    else $error("pin enable changed without write");
  AST_IRQ_MASK: assert property (o_irq |-> $past(mask_sh) != 3'h0)
    else $error("interrupt with all sources masked");
  AST_MASK0: assert property (s_mask_off |-> ##2 !o_irq)
    else $error("interrupt stays after masking");
  AST_PAIR: assert property (&o_timer_out_pin_oe |-> (^o_timer_out_pin) == (^$past(pd_sh)))
    else $error("pin pair polarity wrong");
  AST_UNMAP: assert property (i_rd && i_addr >= 4'he |=> o_rdata == 8'h00)
    else $error("unmapped read not zero");
endmodule
bind tmc_core tmc_core_checker #(.P_VARIANT(P_VARIANT), .P_CNT_W(P_CNT_W)) tmc_core_checker_inst (.i_clk,
  .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_low_clk, .i_ext_count_in, .o_timer_out_pin,
  .o_timer_out_pin_oe, .o_irq);

// File: tb/tmc_far_end.sv
// Far-side model: low clock source, counting pin and output pads.
// Assumes pull-ups on the pads and a pin level set by the bench.
`timescale 1ns/1ps
module tmc_far_end #(
  parameter int P_LOW_HALF = 160
) (
  input wire logic i_ext_lvl,
  input wire logic [1:0] i_pin,
  input wire logic [1:0] i_pin_oe,
  output logic o_low_clk,
  output logic o_ext,
  output logic [1:0] o_pad
);
  initial begin
    o_low_clk = 1'b0;
    #13;
    forever #(P_LOW_HALF) o_low_clk = ~o_low_clk;
  end
  // Pin moves off the core clock edge
  assign #7 o_ext = i_ext_lvl;
  // Released pad floats to its pull-up
  assign o_pad = (i_pin & i_pin_oe) | ~i_pin_oe;
endmodule

// File: tb/tb_tmc_core.sv
// Self-checking bench for the timer core.
// Assumes the far-side model supplies the low clock and counting pin.
`timescale 1ns/1ps
module tb_tmc_core;
  import tmc_pkg::*;
  logic i_clk, i_rst_b, i_wr, i_rd, ext_lvl, low, ext, o_irq;
  logic [3:0] i_addr;
  logic [7:0] i_wdata, o_rdata, rv;
  logic [1:0] pin, oe, pad;
  int bad_count = 0;
  int samples_checked = 0;
  int cyc = 0;
  tmc_core tmc_core_inst (.i_clk, .i_rst_b, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_low_clk(low),
    .i_ext_count_in(ext), .o_timer_out_pin(pin), .o_timer_out_pin_oe(oe), .o_irq);
  tmc_far_end tmc_far_end_inst (.i_ext_lvl(ext_lvl), .i_pin(pin), .i_pin_oe(oe), .o_low_clk(low),
    .o_ext(ext), .o_pad(pad));
  ////////////////////////////////////////
  initial begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      test_done();
    end
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    d = o_rdata;
  endtask
  task automatic wait_irq(output int t);
    @(negedge i_clk);
    while (o_irq !== 1'b1) @(negedge i_clk);
    t = cyc;
  endtask
  task automatic ext_pin(input logic v);
    ext_lvl <= v;
    repeat (6) @(posedge i_clk);
  endtask
  ////////////////////////////////////////
  task automatic t_regs();
    logic [3:0] ad [9] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hb, 4'hc, 4'hd, 4'he};
    wr(4'he, 8'hff);
    for (int i = 0; i < 9; i++) begin
      rd(ad[i], rv);
      chk(16'(rv), (ad[i] == TMC_OFS_PIN_FUNC) ? 16'(TMC_RST_PIN_FUNC) : 16'h0000);
    end
  endtask
  task automatic t_ext();
    logic [7:0] c0;
    wr(TMC_OFS_CMPP_LO, 8'hff);
    rd(TMC_OFS_CNT_LO, c0);
    wr(TMC_OFS_CTRL0, 8'h58);
    ext_pin(1'b1);
    ext_pin(1'b0);
    rd(TMC_OFS_CNT_LO, rv);
    chk(16'(rv), 16'(c0));
    wr(TMC_OFS_CTRL0, 8'h68);
    ext_pin(1'b1);
    rd(TMC_OFS_CNT_LO, rv);
    chk(16'(rv), 16'(c0 + 8'h01));
    ext_pin(1'b0);
    rd(TMC_OFS_CNT_LO, rv);
    chk(16'(rv), 16'(c0 + 8'h01));
    wr(TMC_OFS_CTRL0, 8'h79);
    ext_pin(1'b1);
    ext_pin(1'b0);
    rd(TMC_OFS_CNT_LO, rv);
    chk(16'(rv), 16'(c0 + 8'h02));
  endtask
  task automatic t_div();
    logic [2:0] sel [5] = '{TMC_CK_SYS_DIV4, TMC_CK_SYS, TMC_CK_HIGH_DIV16, TMC_CK_HIGH_DIV64, TMC_CK_LOW};
    int dv [5] = '{4, 1, 16, 64, 8};
    int t1, t2;
    wr(TMC_OFS_CMPP_LO, 8'h07);
    wr(TMC_OFS_CMPA_LO, 8'h02);
    wr(TMC_OFS_CMPB_LO, 8'h04);
    wr(TMC_OFS_INT_MASK, 8'h01);
    for (int i = 0; i < 5; i++) begin
      wr(TMC_OFS_CTRL0, {1'b0, sel[i], 4'h8});
      wr(TMC_OFS_INT_STATUS, 8'h07);
      wait_irq(t1);
      wr(TMC_OFS_INT_STATUS, 8'h01);
      wait_irq(t2);
      chk(16'(t2 - t1), 16'(8 * dv[i]));
    end
    wr(TMC_OFS_CTRL0, 8'h00);
    rd(TMC_OFS_INT_STATUS, rv);
    chk(16'(rv), 16'h0007);
    wr(TMC_OFS_INT_STATUS, 8'h07);
    rd(TMC_OFS_INT_STATUS, rv);
    chk(16'(rv), 16'h0000);
    chk(16'(o_irq), 16'h0000);
    wr(TMC_OFS_INT_MASK, 8'h00);
  endtask
  task automatic t_out();
    tmc_act_t act [3] = '{TMC_ACT_HIGH, TMC_ACT_LOW, TMC_ACT_TOGGLE};
    logic [1:0] exp [3] = '{2'b01, 2'b10, 2'b01};
    int t;
    wr(TMC_OFS_CMPA_LO, 8'h05);
    wr(TMC_OFS_PIN_FUNC, 8'h03);
    wr(TMC_OFS_PORT_DATA, 8'h02);
    wr(TMC_OFS_INT_MASK, 8'h02);
    repeat (2) @(negedge i_clk);
    chk(16'(pad), 16'h0002);
    for (int i = 0; i < 3; i++) begin
      wr(TMC_OFS_CTRL1, {2'h0, act[i], 4'h8});
      wr(TMC_OFS_CTRL0, 8'h18);
      wait_irq(t);
      wr(TMC_OFS_CTRL0, 8'h00);
      wr(TMC_OFS_INT_STATUS, 8'h02);
      @(negedge i_clk);
      chk(16'(pad), 16'(exp[i]));
    end
  endtask
  task automatic t_pwm();
    int n = 0;
    wr(TMC_OFS_PORT_DATA, 8'h00);
    wr(TMC_OFS_CMPA_LO, 8'h02);
    wr(TMC_OFS_CTRL1, 8'h80);
    wr(TMC_OFS_CTRL0, 8'h18);
    repeat (16) @(negedge i_clk);
    repeat (80) begin
      @(negedge i_clk);
      n += pad[0];
    end
    chk(16'(n), 16'h0014);
    wr(TMC_OFS_CTRL0, 8'h00);
    wr(TMC_OFS_PIN_FUNC, 8'h00);
    repeat (2) @(negedge i_clk);
    chk(16'(oe), 16'h0000);
  endtask
  task automatic t_modes();
    wr(TMC_OFS_PIN_FUNC, 8'h01);
    wr(TMC_OFS_CTRL1, 8'h60);
    wr(TMC_OFS_CTRL0, 8'h18);
    repeat (16) @(negedge i_clk);
    chk(16'(pad), 16'h0002);
    wr(TMC_OFS_CTRL0, 8'h00);
    wr(TMC_OFS_CMPA_LO, 8'h40);
    wr(TMC_OFS_CTRL1, 8'hc8);
    wr(TMC_OFS_CTRL0, 8'h18);
    repeat (4) @(negedge i_clk);
    chk(16'(pad), 16'h0003);
    repeat (80) @(negedge i_clk);
    chk(16'(pad), 16'h0002);
    rd(TMC_OFS_CTRL0, rv);
    chk(16'(rv), 16'h0010);
  endtask
  ////////////////////////////////////////
  task automatic test_done();
    $display("checks=%0d mismatches=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    i_rst_b = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    ext_lvl = 1'b0;
    repeat (6) @(posedge i_clk);
    i_rst_b <= 1'b1;
    t_regs();
    t_ext();
    t_div();
    t_out();
    t_pwm();
    t_modes();
    test_done();
  end
endmodule
